// ---- dprbo_regs.svh ----
// Bit positions, byte counts and burst constants of the DDR PSRAM bus slave
`ifndef DPRBO_REGS_SVH
`define DPRBO_REGS_SVH
`define DPRBO_CA_READ        47
`define DPRBO_CA_SPACE       46
`define DPRBO_CA_BURST       45
`define DPRBO_CA_ROW_LSB     16
`define DPRBO_CA_COL_BITS    3
`define DPRBO_CA_LAST_BYTE   3'h5
`define DPRBO_CA_START_BYTE  3'h3
`define DPRBO_WRAP_WORDS     32'h8
`define DPRBO_WORD_HI        15:8
`define DPRBO_WORD_LO        7:0
`endif

// ---- dprbo_pkg.sv ----
// Types shared by the DDR PSRAM bus slave files
package dprbo_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_LAT   = 3'b010,
    ST_RDATA = 3'b011,
    ST_WDATA = 3'b100
  } dprbo_state_t;

  // Levels arriving on the bus pins
  typedef struct packed {
    logic       busClk;
    logic       chipSelN;
    logic       strobeIn;
    logic [7:0] dq;
  } dprbo_pin_in_t;

  // Levels and enables driven onto the bus pins
  typedef struct packed {
    logic [7:0] dqOut;
    logic       dqOeN;
    logic       strobeOut;
    logic       strobeOeN;
  } dprbo_pin_out_t;
endpackage

// ---- dprbo_mem.sv ----
// Word array with byte enables and registered read data
`timescale 1ns/1ps
module dprbo_mem #(
  parameter int ADDR_W = 8
) (
  // System
  input  wire logic              clk,
  input  wire logic              rst,
  // Write port
  input  wire logic              wrEn,
  input  wire logic [1:0]        wrByteEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [15:0]       wrData,
  // Read port
  input  wire logic              rdEn,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [15:0]       rdData
);
  logic [15:0] memArray [0:(1<<ADDR_W)-1];

  // Array itself has no reset, like the real cells
  always_ff @(posedge clk) begin
    if (wrEn && wrByteEn[1]) memArray[wrAddr][15:8] <= wrData[15:8];
    if (wrEn && wrByteEn[0]) memArray[wrAddr][7:0] <= wrData[7:0];
  end

  // Read data comes out of a register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdData <= 16'h0000;
    else if (rdEn) rdData <= memArray[rdAddr];
  end
endmodule

// ---- dprbo_core.sv ----
// Device-side transaction logic of a DDR pseudo-static RAM bus slave
`timescale 1ns/1ps
`include "dprbo_regs.svh"
// Notes on behaviour
// - Register reads: high byte on strobe rise
// - Register writes: high byte rising, low falling
// - Register words always big-endian
// - Latency writes: strobe is host byte mask
// - Zero-latency writes: full words, strobe held low
// - Decode read, space, burst from first word
// - Row from upper words, column from last
// - Array read starts after bits 23:16
// - After latency count, strobe and data start
// - New byte per strobe edge while selected
// - Strobe may pause low at boundaries
// - Wrapped bursts wrap, linear ones advance
// - Past last address, read data undefined
// - Clock may stop while deselected
// - Device drives strobe throughout reads
// - Strobe during command shows extra latency
module dprbo_core import dprbo_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // System
  input  wire logic          clk,
  input  wire logic          rst,
  // Bus pins
  input  wire dprbo_pin_in_t pinIn,
  output dprbo_pin_out_t     pinOut,
  // Configuration
  input  wire logic [3:0]    latencyCount,
  input  wire logic [1:0]    wrapSel,
  input  wire logic          refreshBusy,
  // Register space, command word and array start
  input  wire logic [15:0]   regRdData,
  output logic      [47:0]   commandWord,
  output logic               regWrEn,
  output logic      [15:0]   regWrData,
  output logic               arrayStart
);
  dprbo_pin_in_t s1Reg, s2Reg;
  logic          clkDlyReg;
  dprbo_state_t  stateReg, stateNext;
  logic [47:0]   caReg, caNext;
  logic [2:0]    caCntReg;
  logic [4:0]    latCntReg;
  logic          extraReg, hiMaskReg;
  logic          startSeenReg;
  logic [7:0]    hiByteReg;
  logic [ADDR_W-1:0] addrReg;
  logic [15:0]   memRdData;
  dprbo_pin_out_t outNext;

  // Wrap inside the burst window, or step linearly through the array
  function automatic logic [ADDR_W-1:0] stepAddr(input logic [ADDR_W-1:0] a,
                                                 input logic linear,
                                                 input logic [1:0] sel);
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] inc;
    m   = ADDR_W'((`DPRBO_WRAP_WORDS << sel) - 32'h1);
    inc = a + ADDR_W'(1);
    stepAddr = linear ? inc : ((a & ~m) | (inc & m));
  endfunction

  // Pins pass two flops, the clock one more for edge detection; the first stage is never looked at
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1Reg     <= '{busClk: 1'b0, chipSelN: 1'b1, strobeIn: 1'b0, dq: 8'h00};
      s2Reg     <= '{busClk: 1'b0, chipSelN: 1'b1, strobeIn: 1'b0, dq: 8'h00};
      clkDlyReg <= 1'b0;
    end else begin
      s1Reg     <= pinIn;
      s2Reg     <= s1Reg;
      clkDlyReg <= s2Reg.busClk;
    end
  end

  // Edge detection on the synchronised bus clock; a parked clock just gives no edges
  wire clkRise  = s2Reg.busClk & ~clkDlyReg;
  wire clkFall  = ~s2Reg.busClk & clkDlyReg;
  wire clkEdge  = clkRise | clkFall;
  wire deselect = s2Reg.chipSelN;
  wire inCmd    = (stateReg == ST_CMD);
  wire inLat    = (stateReg == ST_LAT);
  wire inRead   = (stateReg == ST_RDATA);
  wire inWrite  = (stateReg == ST_WDATA);
  wire caDone   = inCmd & clkEdge & (caCntReg == `DPRBO_CA_LAST_BYTE);

  // One command byte per clock edge, first byte in the top bits
  assign caNext = (inCmd && clkEdge) ? {caReg[39:0], s2Reg.dq} : caReg;

  // Transaction kind from the first command word
  wire isRead   = caNext[`DPRBO_CA_READ];
  wire isRegSp  = caNext[`DPRBO_CA_SPACE];
  wire isLinear = caNext[`DPRBO_CA_BURST];
  wire zeroLat  = ~isRead & isRegSp;
  // At the fourth byte only bits 47:16 are in, so the first byte sits 16 bits lower
  wire arrayRead = caNext[`DPRBO_CA_READ - `DPRBO_CA_ROW_LSB] &
                   ~caNext[`DPRBO_CA_SPACE - `DPRBO_CA_ROW_LSB];
  wire [4:0] latTarget = extraReg ? {latencyCount, 1'b0} : {1'b0, latencyCount};
  wire latDone  = inLat & clkFall & ((latCntReg + 5'h01) >= latTarget);

  // Row and upper column from the early words, column from the last
  wire [ADDR_W-1:0] startAddr = {caNext[`DPRBO_CA_ROW_LSB +: ADDR_W-`DPRBO_CA_COL_BITS],
                                 caNext[`DPRBO_CA_COL_BITS-1:0]};
  wire [ADDR_W-1:0] stepped   = stepAddr(addrReg, isLinear, wrapSel);

  // Array read: first word when the command ends, next on each word end
  wire memRdEn = (caDone & isRead & ~isRegSp) | (inRead & clkFall & ~isRegSp);
  wire [ADDR_W-1:0] memRdAddr = caDone ? startAddr : stepped;
  // Register words and array words share the same output path
  wire [15:0] rdWord = isRegSp ? regRdData : memRdData;

  // Array writes honour the host mask; register writes are full words
  wire memWrEn = inWrite & clkFall & ~zeroLat;
  wire [1:0] memByteEn = {~hiMaskReg, ~s2Reg.strobeIn};

  // Next transaction state
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_IDLE:  if (!deselect) stateNext = ST_CMD;
      ST_CMD:   if (caDone) stateNext = zeroLat ? ST_WDATA : ST_LAT;
      ST_LAT:   if (latDone) stateNext = isRead ? ST_RDATA : ST_WDATA;
      ST_RDATA: stateNext = ST_RDATA;
      ST_WDATA: stateNext = ST_WDATA;
      default:  stateNext = ST_IDLE;
    endcase
    if (deselect) stateNext = ST_IDLE;
  end

  // Pin drive for the next cycle
  always_comb begin
    outNext = pinOut;
    outNext.dqOeN = ~(stateNext == ST_RDATA);
    outNext.strobeOeN = ~((stateNext == ST_CMD) || (stateNext == ST_RDATA) ||
                          ((stateNext == ST_LAT) && isRead) ||
                          ((stateNext == ST_WDATA) && zeroLat));
    if (stateNext == ST_CMD) begin
      outNext.strobeOut = extraReg;
    end else if (stateNext != ST_RDATA) begin
      outNext.strobeOut = 1'b0;
    end else if (clkRise) begin
      outNext.dqOut     = rdWord[`DPRBO_WORD_HI];
      outNext.strobeOut = 1'b1;
    end else if (clkFall) begin
      outNext.dqOut     = rdWord[`DPRBO_WORD_LO];
      outNext.strobeOut = 1'b0;
    end
  end

  // Control state and pin registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateReg <= ST_IDLE;
      pinOut   <= '{dqOut: 8'h00, dqOeN: 1'b1, strobeOut: 1'b0, strobeOeN: 1'b1};
      caReg    <= 48'h0;
      extraReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      pinOut   <= outNext;
      caReg    <= caNext;
      if (stateReg == ST_IDLE) extraReg <= refreshBusy;
    end
  end

  // Command byte and latency counters, cleared between transactions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      caCntReg  <= 3'h0;
      latCntReg <= 5'h00;
    end else begin
      caCntReg  <= (stateReg == ST_IDLE) ? 3'h0 : caCntReg + 3'(inCmd & clkEdge);
      latCntReg <= (stateReg == ST_IDLE) ? 5'h00 : latCntReg + 5'(inLat & clkFall);
    end
  end

  // Array start strobe as soon as command bits 23:16 are in
  always_ff @(posedge clk or posedge rst) begin
    if (rst) arrayStart <= 1'b0;
    else arrayStart <= inCmd & clkEdge & (caCntReg == `DPRBO_CA_START_BYTE)
                       & arrayRead;
  end

  // Remembers that the early array start went out in this transaction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) startSeenReg <= 1'b0;
    else startSeenReg <= (stateReg != ST_IDLE) & (startSeenReg | arrayStart);
  end

  // Word address; past the array end a linear burst simply rolls over
  always_ff @(posedge clk or posedge rst) begin
    if (rst) addrReg <= '0;
    else if (caDone) addrReg <= startAddr;
    else if ((inRead || inWrite) && clkFall) addrReg <= stepped;
  end

  // Write capture: high byte and its mask on rise, word done on fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hiByteReg <= 8'h00;
      hiMaskReg <= 1'b0;
      regWrEn   <= 1'b0;
      regWrData <= 16'h0000;
    end else begin
      regWrEn <= inWrite & clkFall & zeroLat;
      if (inWrite && clkRise) begin
        hiByteReg <= s2Reg.dq;
        hiMaskReg <= s2Reg.strobeIn & ~zeroLat;
      end
      if (inWrite && clkFall && zeroLat) regWrData <= {hiByteReg, s2Reg.dq};
    end
  end

  assign commandWord = caReg;

  dprbo_mem #(.ADDR_W(ADDR_W)) uMem (
    .clk      (clk),
    .rst      (rst),
    .wrEn     (memWrEn),
    .wrByteEn (memByteEn),
    .wrAddr   (addrReg),
    .wrData   ({hiByteReg, s2Reg.dq}),
    .rdEn     (memRdEn),
    .rdAddr   (memRdAddr),
    .rdData   (memRdData)
  );

  // Checks kept next to the logic
  property p_hiOnRise;
    @(posedge clk) disable iff (rst)
      (stateNext == ST_RDATA && inRead && clkRise) |=>
        (pinOut.dqOut == $past(rdWord[15:8]) && pinOut.strobeOut);
  endproperty
  a_hiOnRise: assert property (p_hiOnRise) else $error("high byte not on strobe rise");

  property p_loOnFall;
    @(posedge clk) disable iff (rst)
      (stateNext == ST_RDATA && inRead && clkFall) |=>
        (pinOut.dqOut == $past(rdWord[7:0]) && !pinOut.strobeOut);
  endproperty
  a_loOnFall: assert property (p_loOnFall) else $error("low byte not on strobe fall");

  property p_release;
    @(posedge clk) disable iff (rst)
      deselect |=> (pinOut.dqOeN && pinOut.strobeOeN && stateReg == ST_IDLE);
  endproperty
  a_release: assert property (p_release) else $error("lines driven while deselected");

  property p_readStrobe;
    @(posedge clk) disable iff (rst)
      (stateReg == ST_RDATA) |-> !pinOut.strobeOeN && !pinOut.dqOeN;
  endproperty
  a_readStrobe: assert property (p_readStrobe) else $error("strobe not driven in read");

  property p_decode;
    @(posedge clk) disable iff (rst)
      (caDone && !deselect) |=> (stateReg == ($past(zeroLat) ? ST_WDATA : ST_LAT));
  endproperty
  a_decode: assert property (p_decode) else $error("command decode wrong");

  property p_arrayStart;
    @(posedge clk) disable iff (rst)
      caDone |-> (startSeenReg == (isRead && !isRegSp));
  endproperty
  a_arrayStart: assert property (p_arrayStart) else $error("array start missed");

  property p_regWrite;
    @(posedge clk) disable iff (rst)
      (inWrite && clkFall && zeroLat) |=>
        (regWrEn && regWrData == {$past(hiByteReg), $past(s2Reg.dq)});
  endproperty
  a_regWrite: assert property (p_regWrite) else $error("register word not big-endian");

  property p_cmdStrobe;
    @(posedge clk) disable iff (rst)
      (inCmd ##1 inCmd) |-> (pinOut.strobeOut == extraReg && !pinOut.strobeOeN);
  endproperty
  a_cmdStrobe: assert property (p_cmdStrobe) else $error("latency flag not on strobe");

  property p_latency;
    @(posedge clk) disable iff (rst)
      (inLat && stateNext == ST_RDATA) |-> (latCntReg + 5'h01 >= latTarget) && clkFall;
  endproperty
  a_latency: assert property (p_latency) else $error("read data before latency");
endmodule

// ---- dprbo_host.sv ----
// Host bus master model: clock, chip select, command words, write data and mask
`timescale 1ns/1ps
module dprbo_host import dprbo_pkg::*; (
  // System
  input  wire logic           clk,
  // Bus pins
  input  wire dprbo_pin_out_t pinOut,
  output dprbo_pin_in_t       pinIn,
  // Captured read words and extra-latency flag
  output logic                rdDone,
  output logic [15:0]         rdWord,
  output logic [1:0]          rdStb,
  output logic                extraLat
);
  logic        busClk    = 1'b0;
  logic        chipSelN  = 1'b1;
  logic [7:0]  hostDq    = 8'h00;
  logic        hostDqEn  = 1'b1;
  logic        hostStb   = 1'b0;
  logic        hostStbEn = 1'b0;
  logic [7:0]  lastDq    = 8'h00;
  logic        lastStb   = 1'b0;
  logic [15:0] wq[$];
  initial begin
    rdDone = 1'b0;
    extraLat = 1'b0;
  end
  // A released line shows the inverse of its last level, so a stale copy never matches
  assign pinIn.busClk   = busClk;
  assign pinIn.chipSelN = chipSelN;
  assign pinIn.dq       = !pinOut.dqOeN ? pinOut.dqOut : hostDqEn ? hostDq : ~lastDq;
  assign pinIn.strobeIn = !pinOut.strobeOeN ? pinOut.strobeOut : hostStbEn ? hostStb : ~lastStb;
  always @(posedge clk) begin
    lastDq <= pinIn.dq;
    lastStb <= pinIn.strobeIn;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bus clock edge with data and mask set up three clk cycles ahead
  task automatic tick(input logic [7:0] d, input logic s);
    hostDq = d;
    hostStb = s;
    wt(3);
    busClk = ~busClk;
    wt(3);
  endtask
  task automatic xfer(input logic [47:0] ca, input int n, input int lat, input logic [1:0] msk);
    logic [15:0] w;
    logic        zl;
    int          nl;
    zl = !ca[47] && ca[46];
    chipSelN = 1'b0;
    wt(3);
    for (int i = 0; i < 6; i++) begin
      tick(ca[47-8*i -: 8], 1'b0);
      if (i == 1) extraLat = pinIn.strobeIn;
    end
    hostDqEn = !ca[47];
    hostStbEn = !ca[47] && !zl;
    nl = zl ? 0 : (extraLat ? 2 * lat : lat);
    for (int i = 0; i < 2 * nl; i++) tick(8'h00, 1'b0);
    for (int i = 0; i < n; i++) begin
      if (ca[47]) begin
        tick(8'h00, 1'b0);
        wt(2);
        rdWord[15:8] = pinIn.dq;
        rdStb[1] = pinIn.strobeIn;
        tick(8'h00, 1'b0);
        wt(2);
        rdWord[7:0] = pinIn.dq;
        rdStb[0] = pinIn.strobeIn;
        rdDone = 1'b1;
        wt(1);
        rdDone = 1'b0;
      end else begin
        w = wq.pop_front();
        tick(w[15:8], i == 0 && msk[1]);
        tick(w[7:0], i == 0 && msk[0]);
      end
    end
    wt(3);
    chipSelN = 1'b1;
    hostDqEn = 1'b1;
    hostStbEn = 1'b0;
    wt(8);
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking testbench of the DDR PSRAM bus slave against the host model
`timescale 1ns/1ps
module tb_top import dprbo_pkg::*; ();
  logic           clk;
  logic           rst;
  logic [3:0]     latencyCount;
  logic [1:0]     wrapSel;
  logic           refreshBusy;
  logic [15:0]    regRdData;
  logic [47:0]    commandWord;
  logic           regWrEn;
  logic           arrayStart;
  logic           rdDone;
  logic           extraLat;
  logic [15:0]    regWrData;
  logic [15:0]    rdWord;
  logic [1:0]     rdStb;
  logic [15:0]    ww[6];
  logic [15:0]    expQ[$];
  dprbo_pin_in_t  pinIn;
  dprbo_pin_out_t pinOut;
  int             err_total = 0;
  int             check_count = 0;
  int             starts = 0;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  dprbo_core #(.ADDR_W(8)) dut (.clk(clk), .rst(rst), .pinIn(pinIn), .pinOut(pinOut),
    .latencyCount(latencyCount), .wrapSel(wrapSel), .refreshBusy(refreshBusy),
    .regRdData(regRdData), .commandWord(commandWord), .regWrEn(regWrEn),
    .regWrData(regWrData), .arrayStart(arrayStart));
  dprbo_host host (.clk(clk), .pinOut(pinOut), .pinIn(pinIn), .rdDone(rdDone),
    .rdWord(rdWord), .rdStb(rdStb), .extraLat(extraLat));
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Each result that appears takes the oldest expectation
  always @(posedge clk) begin
    if (arrayStart === 1'b1) starts++;
    if (rdDone === 1'b1) check(48'(rdStb), 48'h2);
    if (regWrEn === 1'b1 || rdDone === 1'b1) begin
      if (expQ.size() == 0) check(48'h1, 48'h0);
      else check(48'(rdDone ? rdWord : regWrData), 48'(expQ.pop_front()));
    end
  end
  // One transaction; random latency and refresh demand each time
  task automatic run(input logic [2:0] kind, input logic [4:0] row, input logic [2:0] col,
                     input int n, input logic [1:0] msk);
    logic [47:0] ca;
    int          sc;
    ca = {kind, 24'h0, row, 13'h0, col};
    refreshBusy = 1'($urandom);
    latencyCount = 4'($urandom_range(4, 2));
    host.wt(2);
    sc = starts;
    host.xfer(ca, n, int'(latencyCount), msk);
    check(commandWord, ca);
    check(48'({extraLat, pinOut.dqOeN, pinOut.strobeOeN}), 48'({refreshBusy, 2'b11}));
    check(48'(starts - sc), 48'(kind[2] & ~kind[1]));
    $display("Test done: kind %b row %h col %h words %0d", kind, row, col, n);
  endtask
  initial begin
    rst = 1'b1;
    latencyCount = 4'h2;
    wrapSel = 2'h0;
    refreshBusy = 1'b0;
    regRdData = 16'h0000;
    void'($urandom(48469));
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    host.wt(4);
    check(48'({pinOut.dqOeN, pinOut.strobeOeN, regWrEn, arrayStart}), 48'hc);
    foreach (ww[i]) ww[i] = 16'($urandom);
    regRdData = ww[5] ^ 16'h5a3c;
    expQ.push_back(regRdData);
    run(3'b110, 5'h0, 3'h0, 1, 2'b00);
    for (int i = 0; i < 2; i++) host.wq.push_back(ww[i] ^ 16'h0ff0);
    for (int i = 0; i < 2; i++) expQ.push_back(ww[i] ^ 16'h0ff0);
    run(3'b010, 5'h0, 3'h0, 2, 2'b11);
    for (int i = 0; i < 3; i++) host.wq.push_back(ww[i]);
    run(3'b001, 5'h3, 3'h6, 3, 2'b00);
    host.wq.push_back(ww[3]);
    host.wq.push_back(ww[4]);
    run(3'b000, 5'h3, 3'h7, 2, 2'b00);
    host.wq.push_back(ww[5]);
    run(3'b000, 5'h3, 3'h6, 1, 2'b01);
    expQ.push_back({ww[5][15:8], ww[0][7:0]});
    expQ.push_back(ww[3]);
    expQ.push_back(ww[2]);
    run(3'b101, 5'h3, 3'h6, 3, 2'b00);
    expQ.push_back(ww[3]);
    expQ.push_back(ww[4]);
    run(3'b100, 5'h3, 3'h7, 2, 2'b00);
    // A 16-word window must wrap word 31 to word 16, not to word 24
    wrapSel = 2'h1;
    host.wq.push_back(ww[1]);
    host.wq.push_back(ww[2]);
    run(3'b000, 5'h3, 3'h7, 2, 2'b00);
    expQ.push_back(ww[2]);
    run(3'b101, 5'h2, 3'h0, 1, 2'b00);
    check(48'(expQ.size()), 48'h0);
    end_sim();
  end
  // Watchdog well beyond the expected run of under 1500 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[FAIL] %0t ns: run did not complete", $time);
    end_sim();
  end
endmodule
